// [rtl/fwsr_ctrl.sv]
// fwsr_ctrl: host-side flash program/erase controller with status polling
// assumes an apb master on the system clock and one x8 flash on the pins
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // flash pins
    output logic [fwsr_pkg::ADDR_W-1:0] FL_ADDR,
    input wire logic [fwsr_pkg::DQ_W-1:0] FL_DQ_I,
    output logic [fwsr_pkg::DQ_W-1:0] FL_DQ_O,
    output logic FL_DQ_OE,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    input wire logic FL_READY_BUSY_N
);
    import fwsr_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    fwsr_st_t st_r, st_nxt;
    fwsr_op_t op_r;
    logic [2:0] step_r, step_nxt;
    logic [ADDR_W-1:0] uaddr_r;
    logic [DQ_W-1:0] wdata_r;
    logic [DQ_W-1:0] rdata_r;
    logic pend_r, t1_r, done_r, fail_r, accept_r, timer_r, reject_r;
    logic rb_s1_r, rb_s2_r;
    logic bdone;
    logic [DQ_W-1:0] bdata;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire apb_wr = PSEL && PENABLE && PWRITE;
    wire hit_cmd = (PADDR == REG_CMD);
    wire hit_addr = (PADDR == REG_ADDR);
    wire hit_wdata = (PADDR == REG_WDATA);
    wire hit_stat = (PADDR == REG_STATUS);
    wire mapped = hit_cmd || hit_addr || hit_wdata || hit_stat;
    wire busy = (st_r != M_IDLE);
    // a new command while busy is dropped; software polls the busy bit first
    wire start = apb_wr && hit_cmd && !busy;
    wire [3:0] new_op = PWDATA[3:0];
    wire clr_done = apb_wr && hit_stat && PWDATA[ST_DONE];

    wire [31:0] stat_word = {16'h0000, rdata_r, 1'b0, rb_s2_r, reject_r, timer_r,
                             accept_r, fail_r, done_r, busy};
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = hit_cmd ? {28'h0000000, op_r} :
                    hit_addr ? {11'h000, uaddr_r} :
                    hit_wdata ? {24'h000000, wdata_r} :
                    hit_stat ? stat_word : 32'h00000000;

    // ************************************************************
    // command sequences
    // ************************************************************
    function automatic logic [20:0] seq_word(input fwsr_op_t op, input logic [2:0] s);
        logic [20:0] w;
        w = {1'b1, A_NONE, C_RESET};
        case (op)
            OP_PROG: begin
                case (s)
                    3'h0: w = {1'b0, UNLK_A1, C_UNLK1};
                    3'h1: w = {1'b0, UNLK_A2, C_UNLK2};
                    3'h2: w = {1'b0, UNLK_A1, C_PROG};
                    default: w = {1'b1, A_NONE, C_PROG};
                endcase
            end
            OP_SERASE, OP_CHIP: begin
                case (s)
                    3'h0: w = {1'b0, UNLK_A1, C_UNLK1};
                    3'h1: w = {1'b0, UNLK_A2, C_UNLK2};
                    3'h2: w = {1'b0, UNLK_A1, C_ERSET};
                    3'h3: w = {1'b0, UNLK_A1, C_UNLK1};
                    3'h4: w = {1'b0, UNLK_A2, C_UNLK2};
                    default: w = (op == OP_CHIP) ? {1'b0, UNLK_A1, C_CHIP} :
                                                   {1'b1, A_NONE, C_SECT};
                endcase
            end
            OP_ADD: w = {1'b1, A_NONE, C_SECT};
            OP_SUSP: w = {1'b1, A_NONE, C_SUSP};
            OP_RESUME: w = {1'b1, A_NONE, C_RESUME};
            default: w = {1'b1, A_NONE, C_RESET};
        endcase
        return w;
    endfunction

    wire [20:0] sw = seq_word(op_r, step_r);
    wire [2:0] seq_last = (op_r == OP_PROG) ? LEN_PROG :
                          (op_r == OP_SERASE || op_r == OP_CHIP) ? LEN_ERASE : LEN_ONE;
    wire wr_last = (step_r == seq_last);
    wire bus_st = busy;
    wire bus_wr = (st_r == M_WR) || (st_r == M_RST);
    wire bus_req = bus_st && !pend_r && !bdone;
    // status and sector reads go to the programmed or erasing address
    wire [ADDR_W-1:0] bus_addr = (st_r == M_WR && !sw[20]) ?
                                 {{(ADDR_W-12){1'b0}}, sw[19:8]} : uaddr_r;
    wire [DQ_W-1:0] bus_wdata = (st_r == M_RST) ? C_RESET :
                                (op_r == OP_PROG && sw[20]) ? wdata_r : sw[7:0];
    wire toggling = bdata[DQ_TOG] ^ t1_r;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        step_nxt = step_r;
        case (st_r)
            M_IDLE: begin
                step_nxt = 3'h0;
                if (start) begin
                    case (new_op)
                        OP_ADD: st_nxt = M_PRE;
                        OP_POLL: st_nxt = M_RD1;
                        OP_RDST: st_nxt = M_RDS;
                        OP_NONE: st_nxt = M_IDLE;
                        default: st_nxt = M_WR;
                    endcase
                end
            end
            // a timer bit already high means the add would be ignored
            M_PRE: if (bdone) st_nxt = bdata[DQ_TMR] ? M_IDLE : M_WR;
            M_WR: begin
                if (bdone && !wr_last) begin
                    step_nxt = step_r + 3'h1;
                end else if (bdone) begin
                    case (op_r)
                        OP_PROG, OP_SERASE, OP_CHIP: st_nxt = M_RD1;
                        OP_ADD: st_nxt = M_TMR;
                        default: st_nxt = M_IDLE;
                    endcase
                end
            end
            M_RD1: if (bdone) st_nxt = M_RD2;
            M_RD2: begin
                if (bdone) begin
                    if (op_r == OP_SERASE) begin
                        st_nxt = M_TMR;
                    end else if (!toggling) begin
                        st_nxt = M_IDLE;
                    end else if (bdata[DQ_TMO]) begin
                        st_nxt = M_TM1;
                    end else begin
                        st_nxt = M_RD1;
                    end
                end
            end
            // toggle may stop just as the timeout flag rises, so look again
            M_TM1: if (bdone) st_nxt = M_TM2;
            M_TM2: if (bdone) st_nxt = toggling ? M_RST : M_IDLE;
            M_RST: if (bdone) st_nxt = M_IDLE;
            M_TMR: if (bdone) st_nxt = M_IDLE;
            M_RDS: if (bdone) st_nxt = M_IDLE;
            default: st_nxt = M_IDLE;
        endcase
    end

    // chip erase never looks at the timer bit; it goes straight to polling
    wire op_end = busy && bdone && (st_nxt == M_IDLE);
    wire tmo_fail = (st_r == M_TM2) && bdone && toggling;

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            st_r <= M_IDLE;
            op_r <= OP_NONE;
            step_r <= 3'h0;
            uaddr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            pend_r <= 1'b0;
            t1_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            accept_r <= 1'b0;
            timer_r <= 1'b0;
            reject_r <= 1'b0;
            rb_s1_r <= 1'b1;
            rb_s2_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            step_r <= step_nxt;
            rb_s1_r <= FL_READY_BUSY_N;
            rb_s2_r <= rb_s1_r;
            pend_r <= bus_req ? 1'b1 : (bdone ? 1'b0 : pend_r);
            if (apb_wr && hit_addr && !busy) uaddr_r <= PWDATA[ADDR_W-1:0];
            if (apb_wr && hit_wdata && !busy) wdata_r <= PWDATA[DQ_W-1:0];
            if (start) begin
                op_r <= fwsr_op_t'(new_op);
                fail_r <= 1'b0;
                reject_r <= 1'b0;
            end
            if (bdone && !bus_wr) rdata_r <= bdata;
            if (bdone) t1_r <= bdata[DQ_TOG];
            if (st_r == M_RD2 && bdone && op_r == OP_SERASE) accept_r <= toggling;
            if (tmo_fail) fail_r <= 1'b1;
            if (bdone && (st_r == M_TMR || st_r == M_PRE)) timer_r <= bdata[DQ_TMR];
            if (bdone && (st_r == M_TMR || st_r == M_PRE) && op_r == OP_ADD) begin
                reject_r <= bdata[DQ_TMR];
            end
            // completion wins over a clear in the same cycle
            done_r <= op_end ? 1'b1 : (clr_done ? 1'b0 : done_r);
        end
    end

    // ************************************************************
    // flash bus cycles
    // ************************************************************
    fwsr_fbus u_fbus (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .req(bus_req),
        .wr(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bdone),
        .rdata(bdata),
        .fl_addr(FL_ADDR),
        .fl_dq_i(FL_DQ_I),
        .fl_dq_o(FL_DQ_O),
        .fl_dq_oe(FL_DQ_OE),
        .fl_ce_n(FL_CE_N),
        .fl_oe_n(FL_OE_N),
        .fl_we_n(FL_WE_N)
    );

endmodule
`default_nettype wire

// [rtl/fwsr_pkg.sv]
// fwsr_pkg: constants, op codes and state types of the flash status controller
// assumes an x8 parallel flash and a 20 MHz system clock
package fwsr_pkg;

    // ************************************************************
    // widths and clock
    // ************************************************************
    localparam int ADDR_W = 21;
    localparam int DQ_W = 8;
    localparam int CLK_NS = 50;
    localparam int SYNC_DEPTH = 2;
    // strobe low time, covers the slowest access time with margin
    localparam int T_STROBE_NS = 150;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] WR_LIM = 4'(STROBE_CYC - 1);
    localparam logic [3:0] RD_LIM = 4'(STROBE_CYC + SYNC_DEPTH - 1);

    // ************************************************************
    // apb register map
    // ************************************************************
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_WDATA = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_ACCEPT = 3;
    localparam int ST_TIMER = 4;
    localparam int ST_REJECT = 5;
    localparam int ST_READY = 6;
    localparam int ST_RD_LSB = 8;

    // ************************************************************
    // flash status bit positions
    // ************************************************************
    localparam int DQ_POLL = 7;
    localparam int DQ_TOG = 6;
    localparam int DQ_TMO = 5;
    localparam int DQ_TMR = 3;

    // ************************************************************
    // command sequence words
    // ************************************************************
    localparam logic [11:0] UNLK_A1 = 12'hAAA;
    localparam logic [11:0] UNLK_A2 = 12'h555;
    localparam logic [11:0] A_NONE = 12'h000;
    localparam logic [7:0] C_UNLK1 = 8'hAA;
    localparam logic [7:0] C_UNLK2 = 8'h55;
    localparam logic [7:0] C_PROG = 8'hA0;
    localparam logic [7:0] C_ERSET = 8'h80;
    localparam logic [7:0] C_CHIP = 8'h10;
    localparam logic [7:0] C_SECT = 8'h30;
    localparam logic [7:0] C_SUSP = 8'hB0;
    localparam logic [7:0] C_RESUME = 8'h30;
    localparam logic [7:0] C_RESET = 8'hF0;
    localparam logic [2:0] LEN_ONE = 3'h0;
    localparam logic [2:0] LEN_PROG = 3'h3;
    localparam logic [2:0] LEN_ERASE = 3'h5;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_PROG = 4'h1, OP_SERASE = 4'h2, OP_ADD = 4'h3,
        OP_CHIP = 4'h4, OP_POLL = 4'h5, OP_SUSP = 4'h6, OP_RESUME = 4'h7,
        OP_RESET = 4'h8, OP_RDST = 4'h9
    } fwsr_op_t;

    typedef enum logic [1:0] {
        FB_IDLE = 2'b00, FB_SETUP = 2'b01, FB_STROBE = 2'b11, FB_HOLD = 2'b10
    } fwsr_fb_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0000, M_PRE = 4'b0001, M_WR = 4'b0011, M_RD1 = 4'b0010,
        M_RD2 = 4'b0110, M_TM1 = 4'b0111, M_TM2 = 4'b0101, M_RST = 4'b0100,
        M_TMR = 4'b1100, M_RDS = 4'b1101
    } fwsr_st_t;

endpackage

// [rtl/fwsr_fbus.sv]
// fwsr_fbus: one asynchronous read or write cycle on the flash pins
// assumes req is a one-cycle pulse given only while no cycle is running
`timescale 1ns/10ps
`default_nettype none
module fwsr_fbus (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic req,
    input wire logic wr,
    input wire logic [fwsr_pkg::ADDR_W-1:0] addr,
    input wire logic [fwsr_pkg::DQ_W-1:0] wdata,
    output logic done,
    output logic [fwsr_pkg::DQ_W-1:0] rdata,
    // flash pins
    output logic [fwsr_pkg::ADDR_W-1:0] fl_addr,
    input wire logic [fwsr_pkg::DQ_W-1:0] fl_dq_i,
    output logic [fwsr_pkg::DQ_W-1:0] fl_dq_o,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);
    import fwsr_pkg::*;

    // ************************************************************
    // state and synchroniser
    // ************************************************************
    fwsr_fb_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic wr_r;
    logic [DQ_W-1:0] dq_s1_r, dq_s2_r;

    wire wr_sel = (st_r == FB_IDLE) ? wr : wr_r;
    // reads wait for the sampled data to clear both synchroniser stages
    wire [3:0] lim = wr_r ? WR_LIM : RD_LIM;
    wire at_lim = (st_r == FB_STROBE) && (cnt_r == lim);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            FB_IDLE: begin
                cnt_nxt = 4'h0;
                if (req) begin
                    st_nxt = FB_SETUP;
                end
            end
            FB_SETUP: st_nxt = FB_STROBE;
            FB_STROBE: begin
                if (at_lim) begin
                    st_nxt = FB_HOLD;
                end else begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
            FB_HOLD: st_nxt = FB_IDLE;
            default: st_nxt = FB_IDLE;
        endcase
    end

    // ************************************************************
    // registers and pins
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= FB_IDLE;
            cnt_r <= 4'h0;
            wr_r <= 1'b0;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            rdata <= '0;
            done <= 1'b0;
            fl_addr <= '0;
            fl_dq_o <= '0;
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            dq_s1_r <= fl_dq_i;
            dq_s2_r <= dq_s1_r;
            done <= (st_r == FB_HOLD);
            if (st_r == FB_IDLE && req) begin
                wr_r <= wr;
                fl_addr <= addr;
                fl_dq_o <= wdata;
            end
            if (at_lim && !wr_r) begin
                rdata <= dq_s2_r;
            end
            fl_ce_n <= (st_nxt == FB_IDLE);
            // data stays driven through hold so it outlasts the write strobe
            fl_dq_oe <= wr_sel && (st_nxt != FB_IDLE);
            fl_oe_n <= !((st_nxt == FB_STROBE) && !wr_sel);
            fl_we_n <= !((st_nxt == FB_STROBE) && wr_sel);
        end
    end

endmodule
`default_nettype wire

// [sim/fwsr_ctrl_checker.sv]
// fwsr_ctrl_checker: assertions on the flash pin cycles of the controller
// assumes it is bound into fwsr_ctrl, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module fwsr_ctrl_checker (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // flash pins
    input wire logic [fwsr_pkg::ADDR_W-1:0] FL_ADDR,
    input wire logic [fwsr_pkg::DQ_W-1:0] FL_DQ_O,
    input wire logic FL_DQ_OE,
    input wire logic FL_CE_N,
    input wire logic FL_OE_N,
    input wire logic FL_WE_N
);
    import fwsr_pkg::*;
    // ********
    // flash cycle shape
    // ********
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    chk_we_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*3] ##1 FL_WE_N)
        else $error("write strobe width wrong");
    chk_rd_width: assert property ($fell(FL_OE_N) |-> !FL_OE_N [*5] ##1 FL_OE_N)
        else $error("read strobe width wrong");
    // a separate cycle per read, or the toggle bit never moves
    chk_ce_gap: assert property ($rose(FL_CE_N) |-> FL_CE_N [*2])
        else $error("chip enable gap too short");
    chk_addr_hold: assert property (!FL_CE_N && !$fell(FL_CE_N) |-> $stable(FL_ADDR))
        else $error("address moved within a cycle");
    chk_data_hold: assert property (!FL_WE_N |-> $stable(FL_DQ_O) && FL_DQ_OE && !FL_CE_N)
        else $error("write data not held");
    chk_rd_release: assert property (!FL_OE_N |-> !FL_DQ_OE && FL_WE_N && !FL_CE_N)
        else $error("data bus driven during read");
    chk_idle_pins: assert property (FL_CE_N |-> !FL_DQ_OE && FL_OE_N && FL_WE_N)
        else $error("strobe outside chip enable");
    chk_reset_idle: assert property (disable iff (1'b0) !RESET_N |=> FL_CE_N && !FL_DQ_OE)
        else $error("pins not idle after reset");
endmodule
bind fwsr_ctrl fwsr_ctrl_checker fwsr_ctrl_checker_inst (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
    .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N)
);
`default_nettype wire

// [sim/fwsr_flash_model.sv]
// fwsr_flash_model: behavioural x8 flash with program, sector erase window and suspend
// assumes the bench resolves the data wire; timers count the system clock
`timescale 1ns/10ps
`default_nettype none
module fwsr_flash_model #(
    parameter int WIN_CYC = 300,
    parameter int OP_CYC = 400
) (
    // timer clock
    input wire logic clk,
    // flash pins
    input wire logic [fwsr_pkg::ADDR_W-1:0] addr,
    input wire logic [fwsr_pkg::DQ_W-1:0] din,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [fwsr_pkg::DQ_W-1:0] dout,
    output logic ready_busy_n,
    // fault control
    input wire logic hang,
    output logic rst_seen = 1'b0
);
    import fwsr_pkg::*;
    // ********
    // state
    // ********
    logic [7:0] mem [int];
    logic [31:0] esect = 32'h0;
    logic [7:0] q = 8'h00;
    logic we_q = 1'b1, oe_q = 1'b1, arm = 1'b0, setup = 1'b0, tog = 1'b0, tog2 = 1'b0;
    logic tmo = 1'b0, wbit = 1'b0, sus = 1'b0;
    int win = 0, er = 0, pg = 0;
    wire logic insec = esect[addr[20:16]];
    // released bus shows the inverse, so a late sample cannot pass by luck
    assign dout = (!ce_n && !oe_n) ? q : ~q;
    assign ready_busy_n = !(pg > 0 || win > 0 || (er > 0 && !sus));
    function automatic logic [7:0] rd_val();
        if (pg > 0) return {~wbit, tog, tmo, 5'h00};
        if (sus && insec) return {1'b1, tog, 3'h0, tog2, 2'h0};
        if (!sus && (win > 0 || er > 0)) return {1'b0, tog, tmo, 1'b0, er > 0, tog2 & insec, 2'h0};
        return mem.exists(addr) ? mem[addr] : 8'hFF;
    endfunction
    task automatic wr_cmd(input logic [7:0] d);
        if ((pg > 0 && !tmo) || (er > 0 && !sus && d != C_SUSP)) return;
        if (arm) begin
            mem[addr] = (mem.exists(addr) ? mem[addr] : 8'hFF) & d;
            wbit = d[7];
            pg = OP_CYC;
            arm = 1'b0;
        end else if (d == C_PROG) arm = 1'b1;
        else if (d == C_ERSET) setup = 1'b1;
        else if (d == C_CHIP && setup) begin
            esect = 32'hFFFFFFFF;
            er = OP_CYC;
            setup = 1'b0;
        end else if (d == C_SECT && (setup || win > 0)) begin
            esect[addr[20:16]] = 1'b1;
            win = WIN_CYC;
            setup = 1'b0;
        end else if (d == C_RESUME && sus) sus = 1'b0;
        else if (d == C_SUSP && er > 0) sus = 1'b1;
        else if (d == C_RESET) begin
            rst_seen = 1'b1;
            pg = 0;
            tmo = 1'b0;
        end
    endtask
    // ********
    // bus cycles and timers
    // ********
    always @(posedge clk) begin
        if (oe_q && !oe_n && !ce_n) begin
            q = rd_val();
            if (pg > 0 || (!sus && (win > 0 || er > 0))) tog = !tog;
            if (insec && (win > 0 || er > 0 || sus)) tog2 = !tog2;
        end
        if (!we_q && we_n && !ce_n) wr_cmd(din);
        we_q = we_n;
        oe_q = oe_n;
        if (pg == 1 && hang) tmo = 1'b1;
        else if (pg > 0) pg--;
        if (win == 1) er = OP_CYC;
        if (win > 0) win--;
        if (er > 0 && !sus) begin
            er--;
            if (er == 0) begin
                foreach (mem[k]) if (esect[k[20:16]]) mem[k] = 8'hFF;
                esect = 32'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/test_fwsr_ctrl.sv]
// test_fwsr_ctrl: self-checking bench for the flash status controller
// assumes fwsr_pkg, the bound checker and the behavioural flash model
`timescale 1ns/10ps
`default_nettype none
module test_fwsr_ctrl;
    import fwsr_pkg::*;
    logic CLK_SYS = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic hang = 1'b0, err;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, rd, st;
    wire logic [31:0] PRDATA;
    wire logic PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, rdy_n, rst_seen;
    wire logic [ADDR_W-1:0] FL_ADDR;
    wire logic [DQ_W-1:0] FL_DQ_O, fdq;
    wire logic [DQ_W-1:0] dq = FL_DQ_OE ? FL_DQ_O : fdq;
    int num_errors = 0, checked = 0;
    int exp_mem [int];
    logic [20:0] pa, sa, sb;
    fwsr_ctrl fwsr_ctrl_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR), .FL_DQ_I(dq), .FL_DQ_O(FL_DQ_O),
        .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
        .FL_READY_BUSY_N(rdy_n));
    fwsr_flash_model #(.WIN_CYC(300), .OP_CYC(400)) fwsr_flash_model_inst (.clk(CLK_SYS),
        .addr(FL_ADDR), .din(dq), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
        .dout(fdq), .ready_busy_n(rdy_n), .hang(hang), .rst_seen(rst_seen));
    initial forever #25 CLK_SYS = !CLK_SYS;
    // ********
    // tasks
    // ********
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge CLK_SYS);
            if (PREADY === 1'b1) break;
        end
        if (n == 20) begin
            $display("ERROR pready expected 1 seen 0");
            num_errors++;
            end_of_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // clears done, starts one op and waits for busy to fall
    task automatic op(input logic [3:0] c, input logic [20:0] a);
        int n;
        apb(1'b1, REG_STATUS, 32'h2);
        apb(1'b1, REG_ADDR, {11'h000, a});
        apb(1'b1, REG_CMD, {28'h0, c});
        for (n = 0; n < 3000; n++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        if (n == 3000) begin
            $display("ERROR busy expected 0 seen 1");
            num_errors++;
            end_of_test();
        end
        st = rd;
        chk("done", 32'h1, st[ST_DONE]);
    endtask
    task automatic prog(input logic [20:0] a);
        logic [7:0] d;
        d = 8'($urandom);
        exp_mem[a] = d;
        apb(1'b1, REG_WDATA, {24'h0, d});
        op(4'h1, a);
        chk("prog fail", 32'h0, st[ST_FAIL]);
    endtask
    task automatic rd_chk(input logic [20:0] a);
        op(4'h9, a);
        chk("array byte", exp_mem.exists(a) ? exp_mem[a] : 32'hFF, st[15:8]);
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        logic t;
        void'($urandom(32'h2F8B));
        repeat (5) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status reset", 32'h40, rd);
        chk("status err", 32'h0, err);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        pa = {5'h03, 16'($urandom)};
        sa = {5'h05, 16'($urandom)};
        sb = {5'h07, 16'($urandom)};
        prog(pa);
        prog(sb);
        rd_chk(pa);
        apb(1'b0, REG_ADDR, 32'h0);
        chk("addr reg", {11'h000, pa}, rd);
        apb(1'b0, REG_CMD, 32'h0);
        chk("cmd reg", 32'h9, rd);
        op(4'h2, sa);
        chk("accepted", 32'h1, st[ST_ACCEPT]);
        chk("timer open", 32'h0, st[ST_TIMER]);
        op(4'h3, sb);
        chk("add taken", 32'h0, st[ST_REJECT]);
        repeat (400) @(posedge CLK_SYS);
        op(4'h3, pa);
        chk("add refused", 32'h1, st[ST_REJECT]);
        chk("timer closed", 32'h1, st[ST_TIMER]);
        op(4'h5, sa);
        chk("erase fail", 32'h0, st[ST_FAIL]);
        exp_mem.delete(sb);
        rd_chk(sb);
        rd_chk(pa);
        prog(sb);
        op(4'h2, sa);
        repeat (400) @(posedge CLK_SYS);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("busy pin", 32'h0, rd[ST_READY]);
        op(4'h6, sa);
        op(4'h9, sa);
        chk("suspended poll", 32'h1, st[15]);
        t = st[14];
        pa[0] = st[10];
        op(4'h9, sa);
        chk("toggle still", t, st[14]);
        chk("sector toggles", !pa[0], st[10]);
        chk("ready pin", 32'h1, st[ST_READY]);
        rd_chk(sb);
        op(4'h7, sa);
        op(4'h5, sa);
        chk("resume fail", 32'h0, st[ST_FAIL]);
        hang <= 1'b1;
        apb(1'b1, REG_WDATA, 32'h5A);
        op(4'h1, {5'h0B, 16'($urandom)});
        chk("timeout fail", 32'h1, st[ST_FAIL]);
        chk("reset issued", 32'h1, rst_seen);
        hang <= 1'b0;
        op(4'h4, 21'h0);
        chk("chip fail", 32'h0, st[ST_FAIL]);
        exp_mem.delete();
        rd_chk(sb);
        op(4'h8, sb);
        chk("reset op fail", 32'h0, st[ST_FAIL]);
        end_of_test();
    end
endmodule
`default_nettype wire
